// [hw/tsg_cfg_pkg.sv]
package tsg_cfg_pkg;
    // register addresses of the parallel register port
    localparam logic [3:0] ADDR_MODE_GAIN   = 4'h0;
    localparam logic [3:0] ADDR_TONE_ATTEN  = 4'h1;
    localparam logic [3:0] ADDR_ROUTE_RATE  = 4'h2;
    localparam logic [3:0] ADDR_RATE_FACTOR = 4'h3;
    localparam logic [3:0] ADDR_SCALE_LOW   = 4'h4;
    localparam logic [3:0] ADDR_SCALE_MID   = 4'h5;
    localparam logic [3:0] ADDR_SCALE_HIGH  = 4'h6;
    localparam logic [3:0] ADDR_LEVEL_A     = 4'h7;
    localparam logic [3:0] ADDR_LEVEL_B     = 4'h8;
    // reset values
    localparam logic [7:0] RST_MODE_GAIN    = 8'h18;
    localparam logic [7:0] RST_TONE_ATTEN   = 8'h00;
    localparam logic [7:0] RST_ROUTE_RATE   = 8'h00;
    localparam logic [7:0] RST_RATE_FACTOR  = 8'h07;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    // field positions
    localparam int RANGE_BIT     = 7;
    localparam int PATH_HI       = 6;
    localparam int PATH_LO       = 4;
    localparam int RATE_M_HI     = 3;
    localparam int LEVEL_HI      = 4;
    localparam int MODE_HI       = 1;
    localparam int GAIN_HI       = 4;
    localparam int GAIN_LO       = 2;
    // mute threshold of the attenuation code
    localparam logic [7:0] MUTE_FROM = 8'hf0;
    // id bits read back; value is arbitrary
    localparam logic [2:0] ID_CODE   = 3'h5;

    typedef enum logic [1:0] {
        TSG_MODE_SINE  = 2'h0,
        TSG_MODE_DC    = 2'h1,
        TSG_MODE_DATA  = 2'h2,
        TSG_MODE_PULSE = 2'h3
    } tsg_mode_t;

    // switch terminal map: {pin->pout, pin->nout, nin->pout, nin->nout, pout<->nout}
    typedef enum logic [2:0] {
        TSG_SW_OPEN  = 3'h0,
        TSG_SW_DIFF  = 3'h1,
        TSG_SW_REV   = 3'h2,
        TSG_SW_CMP   = 3'h3,
        TSG_SW_CMN   = 3'h4,
        TSG_SW_SEP   = 3'h5,
        TSG_SW_SEN   = 3'h6,
        TSG_SW_SHORT = 3'h7
    } tsg_path_t;
endpackage

// [hw/tsg_cfg.sv]
// Operation
// - sine digital gain is minus the attenuation code over two, in 0.5 dB steps.
// - attenuation codes f0 through ff fully mute the sine output.
// - bit 7 of the routing-and-rate register selects the sine frequency range.
// - with the route-enable pin high the 3-bit path field drives the switch.
// - outside data mode, with the route-enable pin low every switch is forced open.
// - in digital data mode the path field alone drives the switch.
// - path codes 0..3 are open, straight, crossed and positive to both outputs.
// - path codes 4..7 are negative to both, positive single, negative single, short.
// - the low four bits of the routing-and-rate register are one frequency factor.
// - the 8-bit rate factor register is a second frequency factor.
// - the 24-bit level scale word is built from addresses 4 (low) to 6 (high).
// - level a, the low five bits of its register, is output while sync is low.
// - in pulse mode the sync pin chooses between the two pulse levels.
// - pulse levels ignore the analog output range setting.
// - level b is the low five bits of its register; upper three bits stay zero.
// - mode codes are sine, dc, data, pulse; a mode change resets the generator.
`timescale 1ns/1ps
module tsg_cfg #(
    parameter int LEVEL_W = 5
) (
    input  wire logic               i_ref_clk,
    input  wire logic               i_reset,
    input  wire logic               i_wr_en,
    input  wire logic               i_rd_en,
    input  wire logic [3:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_route_enable_pin,
    input  wire logic               i_sync_pin,
    output logic      [7:0]         o_rdata,
    output logic      [7:0]         o_attenuation_code,
    output logic                    o_tone_mute,
    output logic                    o_range_select_bit,
    output logic      [3:0]         o_rate_m,
    output logic      [7:0]         o_rate_n,
    output logic      [4:0]         o_switch_map,
    output logic      [23:0]        o_level_scale,
    output logic      [LEVEL_W-1:0] o_pulse_level,
    output logic                    o_pulse_active,
    output logic      [1:0]         o_mode,
    output logic      [2:0]         o_range_gain,
    output logic                    o_gen_reset
);
    // field bounds brought in once so part-selects stay short
    localparam int GAIN_HI_C  = tsg_cfg_pkg::GAIN_HI;
    localparam int GAIN_LO_C  = tsg_cfg_pkg::GAIN_LO;
    localparam int MODE_HI_C  = tsg_cfg_pkg::MODE_HI;
    localparam int PATH_HI_C  = tsg_cfg_pkg::PATH_HI;
    localparam int PATH_LO_C  = tsg_cfg_pkg::PATH_LO;
    localparam int LEVEL_HI_C = tsg_cfg_pkg::LEVEL_HI;
    localparam int RANGE_C    = tsg_cfg_pkg::RANGE_BIT;
    localparam int RATE_HI_C  = tsg_cfg_pkg::RATE_M_HI;

    typedef struct packed {
        logic [7:0]         mode_gain;
        logic [7:0]         tone_atten;
        logic [7:0]         route_rate;
        logic [7:0]         rate_factor;
        logic [7:0]         scale_low;
        logic [7:0]         scale_mid;
        logic [7:0]         scale_high;
        logic [7:0]         level_a;
        logic [7:0]         level_b;
        logic [2:0]         route_sync;
        logic [2:0]         level_sync;
        logic               route_en;
        logic               sync_lvl;
        logic [7:0]         rdata;
        logic               mute;
        logic [4:0]         switch_map;
        logic [LEVEL_W-1:0] pulse_level;
        logic               pulse_active;
        logic               gen_reset;
    } tsg_state_t;

    tsg_state_t state_r;
    tsg_state_t state_nxt;
    logic [1:0] mode_now;
    logic [2:0] path_now;
    logic [7:0] rd_mux;

    // three-stage pin synchroniser: stage 0 takes the pin, stage 2 is the oldest
    function automatic logic [2:0] tsg_sync_shift(input logic [2:0] stages,
                                                  input logic       pin);
        tsg_sync_shift = {stages[1:0], pin};
    endfunction

    // a level counts only once stages two and three agree, so a glitch is ignored
    function automatic logic tsg_sync_accept(input logic [2:0] stages,
                                             input logic       held);
        if (stages[1] == stages[2]) begin
            tsg_sync_accept = stages[2];
        end else begin
            tsg_sync_accept = held;
        end
    endfunction

    // codes at or above the threshold mute; below it the code is half-dB attenuation
    function automatic logic tsg_is_muted(input logic [7:0] code);
        tsg_is_muted = (code >= tsg_cfg_pkg::MUTE_FROM);
    endfunction

    function automatic logic [1:0] tsg_mode_of(input logic [7:0] mode_gain);
        tsg_mode_of = mode_gain[MODE_HI_C:0];
    endfunction

    function automatic logic tsg_addr_mapped(input logic [3:0] addr);
        tsg_addr_mapped = (addr <= tsg_cfg_pkg::ADDR_LEVEL_B);
    endfunction

    // terminal connections per path code
    function automatic logic [4:0] tsg_path_decode(input logic [2:0] code);
        case (tsg_cfg_pkg::tsg_path_t'(code))
            tsg_cfg_pkg::TSG_SW_OPEN: begin
                tsg_path_decode = 5'h00;
            end
            tsg_cfg_pkg::TSG_SW_DIFF: begin
                tsg_path_decode = 5'h12;
            end
            tsg_cfg_pkg::TSG_SW_REV: begin
                tsg_path_decode = 5'h0c;
            end
            tsg_cfg_pkg::TSG_SW_CMP: begin
                tsg_path_decode = 5'h18;
            end
            tsg_cfg_pkg::TSG_SW_CMN: begin
                tsg_path_decode = 5'h06;
            end
            tsg_cfg_pkg::TSG_SW_SEP: begin
                tsg_path_decode = 5'h10;
            end
            tsg_cfg_pkg::TSG_SW_SEN: begin
                tsg_path_decode = 5'h02;
            end
            tsg_cfg_pkg::TSG_SW_SHORT: begin
                tsg_path_decode = 5'h01;
            end
            default: begin
                tsg_path_decode = 5'h00;
            end
        endcase
    endfunction

    // read-back view of a register; id bits replace the upper three of register 0
    function automatic logic [7:0] tsg_read_mux(input tsg_state_t s,
                                                input logic [3:0] addr);
        case (addr)
            tsg_cfg_pkg::ADDR_MODE_GAIN: begin
                tsg_read_mux = {tsg_cfg_pkg::ID_CODE, s.mode_gain[GAIN_HI_C:0]};
            end

            tsg_cfg_pkg::ADDR_TONE_ATTEN: begin
                tsg_read_mux = s.tone_atten;
            end

            tsg_cfg_pkg::ADDR_ROUTE_RATE: begin
                tsg_read_mux = s.route_rate;
            end

            tsg_cfg_pkg::ADDR_RATE_FACTOR: begin
                tsg_read_mux = s.rate_factor;
            end

            tsg_cfg_pkg::ADDR_SCALE_LOW: begin
                tsg_read_mux = s.scale_low;
            end

            tsg_cfg_pkg::ADDR_SCALE_MID: begin
                tsg_read_mux = s.scale_mid;
            end

            tsg_cfg_pkg::ADDR_SCALE_HIGH: begin
                tsg_read_mux = s.scale_high;
            end

            tsg_cfg_pkg::ADDR_LEVEL_A: begin
                tsg_read_mux = s.level_a;
            end

            tsg_cfg_pkg::ADDR_LEVEL_B: begin
                tsg_read_mux = s.level_b;
            end

            default: begin
                tsg_read_mux = tsg_cfg_pkg::RST_ZERO;
            end
        endcase
    endfunction

    // range gain is not consulted: pulse levels are absolute
    function automatic logic [LEVEL_W-1:0] tsg_level_pick(input logic       sync_high,
                                                          input logic [7:0] lvl_a,
                                                          input logic [7:0] lvl_b);
        if (sync_high) begin
            tsg_level_pick = lvl_b[LEVEL_W-1:0];
        end else begin
            tsg_level_pick = lvl_a[LEVEL_W-1:0];
        end
    endfunction

    // data mode bypasses the enable pin
    function automatic logic [4:0] tsg_switch_pick(input logic [1:0] mode,
                                                   input logic       route_on,
                                                   input logic [2:0] path);
        if (tsg_cfg_pkg::tsg_mode_t'(mode) == tsg_cfg_pkg::TSG_MODE_DATA) begin
            tsg_switch_pick = tsg_path_decode(path);
        end else if (route_on) begin
            tsg_switch_pick = tsg_path_decode(path);
        end else begin
            tsg_switch_pick = 5'h00;
        end
    endfunction

    always_comb begin
        state_nxt = state_r;
        mode_now  = '0;
        path_now  = '0;
        rd_mux    = '0;

        // pins pass three flops; a change counts once stages two and three agree
        state_nxt.route_sync = tsg_sync_shift(state_r.route_sync, i_route_enable_pin);
        state_nxt.level_sync = tsg_sync_shift(state_r.level_sync, i_sync_pin);
        state_nxt.route_en   = tsg_sync_accept(state_r.route_sync, state_r.route_en);
        state_nxt.sync_lvl   = tsg_sync_accept(state_r.level_sync, state_r.sync_lvl);

        if (i_wr_en) begin
            case (i_addr)
                tsg_cfg_pkg::ADDR_MODE_GAIN: begin
                    // id bits are read-only
                    state_nxt.mode_gain[GAIN_HI_C:0] = i_wdata[GAIN_HI_C:0];
                end

                tsg_cfg_pkg::ADDR_TONE_ATTEN: begin
                    state_nxt.tone_atten = i_wdata;
                end

                tsg_cfg_pkg::ADDR_ROUTE_RATE: begin
                    state_nxt.route_rate = i_wdata;
                end

                tsg_cfg_pkg::ADDR_RATE_FACTOR: begin
                    state_nxt.rate_factor = i_wdata;
                end

                tsg_cfg_pkg::ADDR_SCALE_LOW: begin
                    state_nxt.scale_low = i_wdata;
                end

                tsg_cfg_pkg::ADDR_SCALE_MID: begin
                    state_nxt.scale_mid = i_wdata;
                end

                tsg_cfg_pkg::ADDR_SCALE_HIGH: begin
                    state_nxt.scale_high = i_wdata;
                end

                // reserved bits are not stored so they always read zero
                tsg_cfg_pkg::ADDR_LEVEL_A: begin
                    state_nxt.level_a = {3'h0, i_wdata[LEVEL_HI_C:0]};
                end

                tsg_cfg_pkg::ADDR_LEVEL_B: begin
                    state_nxt.level_b = {3'h0, i_wdata[LEVEL_HI_C:0]};
                end

                default: begin
                end
            endcase
        end

        // a mode change pulses the generator reset for one cycle
        mode_now = tsg_mode_of(state_nxt.mode_gain);
        state_nxt.gen_reset = (mode_now != tsg_mode_of(state_r.mode_gain));
        state_nxt.pulse_active =
            (tsg_cfg_pkg::tsg_mode_t'(mode_now) == tsg_cfg_pkg::TSG_MODE_PULSE);

        // derived outputs follow the next register value, so they move with it
        state_nxt.mute = tsg_is_muted(state_nxt.tone_atten);
        path_now = state_nxt.route_rate[PATH_HI_C:PATH_LO_C];
        state_nxt.switch_map = tsg_switch_pick(mode_now, state_nxt.route_en, path_now);
        state_nxt.pulse_level = tsg_level_pick(state_nxt.sync_lvl,
                                               state_nxt.level_a,
                                               state_nxt.level_b);

        // a read returns the registers as they stand before this edge
        if (tsg_addr_mapped(i_addr)) begin
            rd_mux = tsg_read_mux(state_r, i_addr);
        end else begin
            rd_mux = tsg_cfg_pkg::RST_ZERO;
        end
        if (i_rd_en) begin
            state_nxt.rdata = rd_mux;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r.mode_gain    <= tsg_cfg_pkg::RST_MODE_GAIN;
            state_r.tone_atten   <= tsg_cfg_pkg::RST_TONE_ATTEN;
            state_r.route_rate   <= tsg_cfg_pkg::RST_ROUTE_RATE;
            state_r.rate_factor  <= tsg_cfg_pkg::RST_RATE_FACTOR;
            state_r.scale_low    <= tsg_cfg_pkg::RST_ZERO;
            state_r.scale_mid    <= tsg_cfg_pkg::RST_ZERO;
            state_r.scale_high   <= tsg_cfg_pkg::RST_ZERO;
            state_r.level_a      <= tsg_cfg_pkg::RST_ZERO;
            state_r.level_b      <= tsg_cfg_pkg::RST_ZERO;
            state_r.route_sync   <= '0;
            state_r.level_sync   <= '0;
            state_r.route_en     <= 1'b0;
            state_r.sync_lvl     <= 1'b0;
            state_r.rdata        <= tsg_cfg_pkg::RST_ZERO;
            state_r.mute         <= 1'b0;
            state_r.switch_map   <= '0;
            state_r.pulse_level  <= '0;
            state_r.pulse_active <= 1'b0;
            state_r.gen_reset    <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // all outputs are flop fields of the state
    assign o_rdata            = state_r.rdata;
    assign o_attenuation_code = state_r.tone_atten;
    assign o_tone_mute        = state_r.mute;
    assign o_range_select_bit = state_r.route_rate[RANGE_C];
    assign o_rate_m           = state_r.route_rate[RATE_HI_C:0];
    assign o_rate_n           = state_r.rate_factor;
    assign o_switch_map       = state_r.switch_map;
    assign o_level_scale      = {state_r.scale_high,
                                 state_r.scale_mid,
                                 state_r.scale_low};
    assign o_pulse_level      = state_r.pulse_level;
    assign o_pulse_active     = state_r.pulse_active;
    assign o_mode             = state_r.mode_gain[MODE_HI_C:0];
    assign o_range_gain       = state_r.mode_gain[GAIN_HI_C:GAIN_LO_C];
    assign o_gen_reset        = state_r.gen_reset;
endmodule

// [bench/tsg_cfg_host.sv]
`timescale 1ns/1ps
module tsg_cfg_host (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic      [3:0] o_addr,
    output logic      [7:0] o_wdata
);
    initial {o_wr_en, o_rd_en, o_addr, o_wdata} = 14'h0000;
    // no release inside wr, so writes may run back to back
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        #1;
        {o_wr_en, o_rd_en, o_addr} = {2'b10, a};
        o_wdata = (a == 4'h7 || a == 4'h8) ? {3'h0, d[4:0]} : d;
    endtask
    task automatic idle;
        @(posedge i_ref_clk);
        #1;
        {o_wr_en, o_rd_en} = 2'b00;
        // released lines show the inverse, never a stale match
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        #1;
        {o_wr_en, o_rd_en, o_addr} = {2'b01, a};
        idle;
        d = i_rdata;
    endtask
endmodule

// [bench/tsg_cfg_properties.sv]
`timescale 1ns/1ps
module tsg_cfg_properties #(
    parameter int LEVEL_W = 5
) (
    input wire logic               i_ref_clk,
    input wire logic               i_reset,
    input wire logic               i_wr_en,
    input wire logic [3:0]         i_addr,
    input wire logic [7:0]         i_wdata,
    input wire logic               i_route_enable_pin,
    input wire logic               i_sync_pin,
    input wire logic [7:0]         o_attenuation_code,
    input wire logic               o_tone_mute,
    input wire logic               o_range_select_bit,
    input wire logic [3:0]         o_rate_m,
    input wire logic [7:0]         o_rate_n,
    input wire logic [4:0]         o_switch_map,
    input wire logic [23:0]        o_level_scale,
    input wire logic [LEVEL_W-1:0] o_pulse_level,
    input wire logic [1:0]         o_mode,
    input wire logic               o_gen_reset
);
    localparam logic [4:0] MAP [8] = '{5'h00, 5'h12, 5'h0c, 5'h18, 5'h06, 5'h10, 5'h02, 5'h01};
    wire logic [8:0] hit = i_wr_en ? 9'(9'h001 << i_addr) : 9'h000;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_mute_level: assert property (o_tone_mute == (o_attenuation_code >= 8'hf0))
        else $error("mute flag wrong");
    a_atten_write: assert property (hit[1] |=> o_attenuation_code == $past(i_wdata))
        else $error("attenuation not stored");
    a_range_rate: assert property (hit[2] |=> {o_range_select_bit, o_rate_m} ==
        $past({i_wdata[7], i_wdata[3:0]})) else $error("range or rate wrong");
    a_factor_write: assert property (hit[3] |=> o_rate_n == $past(i_wdata))
        else $error("rate factor wrong");
    a_scale_msb: assert property (hit[6] |=> o_level_scale[23:16] == $past(i_wdata))
        else $error("scale byte order wrong");
    a_switch_open: assert property ((!i_route_enable_pin[*7] ##0 o_mode != 2'h2) |->
        o_switch_map == 5'h00) else $error("switch not open");
    a_switch_data: assert property (hit[2] && o_mode == 2'h2 |=>
        o_switch_map == MAP[$past(i_wdata[6:4])]) else $error("data mode switch wrong");
    a_switch_on: assert property ((i_route_enable_pin[*7] ##0 hit[2]) |=>
        o_switch_map == MAP[$past(i_wdata[6:4])]) else $error("enabled switch wrong");
    a_level_a: assert property ((!i_sync_pin[*7] ##0 hit[7]) |=>
        o_pulse_level == $past(i_wdata[4:0])) else $error("level a wrong");
    a_level_b: assert property ((i_sync_pin[*7] ##0 hit[8]) |=>
        o_pulse_level == $past(i_wdata[4:0])) else $error("level b wrong");
    a_mode_restart: assert property (hit[0] && i_wdata[1:0] != o_mode |=> o_gen_reset)
        else $error("no restart on mode change");
    a_restart_cause: assert property (o_gen_reset |-> $past(hit[0]))
        else $error("restart without mode write");
endmodule
bind tsg_cfg tsg_cfg_properties #(.LEVEL_W(LEVEL_W)) u_props (.i_ref_clk, .i_reset, .i_wr_en,
    .i_addr, .i_wdata, .i_route_enable_pin, .i_sync_pin, .o_attenuation_code, .o_tone_mute,
    .o_range_select_bit, .o_rate_m, .o_rate_n, .o_switch_map, .o_level_scale, .o_pulse_level,
    .o_mode, .o_gen_reset);

// [bench/tsg_cfg_bench.sv]
`timescale 1ns/1ps
module tsg_cfg_bench;
    logic        i_ref_clk = 1'b0;
    logic        i_reset   = 1'b1;
    logic        en        = 1'b0;
    logic        sy        = 1'b0;
    logic        i_wr_en, i_rd_en, o_tone_mute, o_range_select_bit, o_pulse_active, o_gen_reset;
    logic [3:0]  i_addr, o_rate_m;
    logic [7:0]  i_wdata, o_rdata, o_attenuation_code, o_rate_n, d;
    logic [7:0]  m [16];
    logic [4:0]  o_switch_map, o_pulse_level;
    logic [23:0] o_level_scale;
    logic [1:0]  o_mode;
    logic [2:0]  o_range_gain;
    logic        gr;
    int          failures = 0, check_count = 0, seed = 31823, i, k;
    logic [4:0]  SM [8] = '{5'h00, 5'h12, 5'h0c, 5'h18, 5'h06, 5'h10, 5'h02, 5'h01};
    always #50 i_ref_clk = ~i_ref_clk;
    tsg_cfg_host host (.i_ref_clk, .i_rdata(o_rdata), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wdata(i_wdata));
    tsg_cfg dut (.i_ref_clk, .i_reset, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
        .i_route_enable_pin(en), .i_sync_pin(sy), .o_rdata, .o_attenuation_code, .o_tone_mute,
        .o_range_select_bit, .o_rate_m, .o_rate_n, .o_switch_map, .o_level_scale,
        .o_pulse_level, .o_pulse_active, .o_mode, .o_range_gain, .o_gen_reset);
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // unmapped addresses read as zero
    task automatic rd_all;
        for (k = 0; k < 16; k++) begin
            host.rd(4'(k), d);
            chk_rd(d, k == 0 ? {tsg_cfg_pkg::ID_CODE, m[0][4:0]} : k < 9 ? m[k] : 8'h00);
        end
    endtask
    initial begin
        repeat (3000) @(posedge i_ref_clk);
        failures++;
        stop_test;
    end
    initial begin
        for (k = 0; k < 16; k++) m[k] = 8'h00;
        m[0] = 8'h18;
        m[3] = 8'h07;
        repeat (12) @(posedge i_ref_clk);
        #1 i_reset = 1'b0;
        rd_all;
        for (i = 0; i < 40; i++) begin
            d = $random(seed);
            if (i % 10 == 0) d[1:0] = 2'(i / 10);
            if (i == 1) d = 8'hef;
            if (i == 11) d = 8'hf0;
            if (i % 10 == 7 || i % 10 == 8) d[7:5] = 3'h0;
            gr = (i % 10 == 0) && d[1:0] != m[0][1:0];
            host.wr(4'(i % 10), d);
            if (i % 10 < 9) m[i % 10] = d;
            host.idle;
            en = i[0] ^ i[3];
            sy = i[1];
            chk_out({o_attenuation_code, o_tone_mute, o_range_select_bit, o_rate_m, o_rate_n,
                o_level_scale, o_range_gain, o_mode, o_pulse_active, o_gen_reset},
                {m[1], m[1] >= 8'hf0, m[2][7], m[2][3:0], m[3], m[6], m[5], m[4], m[0][4:0],
                m[0][1:0] == 2'h3, gr});
            repeat (8) @(posedge i_ref_clk);
            #1;
            chk_out({o_switch_map, o_pulse_level, o_gen_reset}, {(en || m[0][1:0] == 2'h2) ?
                SM[m[2][6:4]] : 5'h00, sy ? m[8][4:0] : m[7][4:0], 1'b0});
        end
        rd_all;
        stop_test;
    end
endmodule
